/* File: design/addr_splitter.sv */
// splits a linear byte address into bank, row, column, offset and byte lanes
`timescale 1ns/1ns
`default_nettype none
module addr_splitter (
  input wire logic [sdram_map_pkg::ADDR_W-1:0] addr_i,
  input wire logic [1:0] size_i,
  input wire logic [1:0] cfg_rows_i,
  input wire logic [1:0] cfg_cols_i,
  input wire logic cfg_bus16_i,
  map_fields_if.producer fld
);
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  // reserved row code falls back to 8k so the bank never slides off the top
  wire [1:0] rows_sel = (cfg_rows_i > sdram_map_pkg::ROWS_8K) ? sdram_map_pkg::ROWS_8K : cfg_rows_i;
  wire [4:0] col_lsb = cfg_bus16_i ? sdram_map_pkg::COL_LSB_16 : sdram_map_pkg::COL_LSB_32;
  wire [4:0] col_w = sdram_map_pkg::COL_W_MIN + {3'h0, cfg_cols_i};
  wire [4:0] row_w = sdram_map_pkg::ROW_W_MIN + {3'h0, rows_sel};
  wire [4:0] row_lsb = col_lsb + col_w;
  wire [4:0] bank_lsb = row_lsb + row_w;
  wire [10:0] col_mask = 11'h7FF >> (2'h3 - cfg_cols_i);
  wire [12:0] row_mask = 13'h1FFF >> (2'h2 - rows_sel);
  // ------------------------------------------------------------
  // extraction; the 16-bit layout is the 32-bit one moved down one bit
  // ------------------------------------------------------------
  assign fld.col = 11'(addr_i >> col_lsb) & col_mask;
  assign fld.row = 13'(addr_i >> row_lsb) & row_mask;
  assign fld.bank_field = 2'(addr_i >> bank_lsb);
  assign fld.offset = cfg_bus16_i ? {1'b0, addr_i[0]} : addr_i[1:0];
  // ------------------------------------------------------------
  // byte lanes from size and offset; a 16-bit bus only has the low two
  // ------------------------------------------------------------
  wire [3:0] lanes32 = (size_i == sdram_map_pkg::SIZE_BYTE) ? (4'h1 << addr_i[1:0]) :
                       (size_i == sdram_map_pkg::SIZE_HALF) ? (addr_i[1] ? 4'hC : 4'h3) :
                       4'hF;
  wire [3:0] lanes16 = (size_i == sdram_map_pkg::SIZE_BYTE) ? (addr_i[0] ? 4'h2 : 4'h1) :
                       4'h3;
  assign fld.lane_en = cfg_bus16_i ? lanes16 : lanes32;
endmodule
`default_nettype wire

/* File: design/map_fields_if.sv */
// decoded address fields passed from the splitter to the controller
`timescale 1ns/1ns
`default_nettype none
interface map_fields_if;
  logic [1:0] bank_field;
  logic [sdram_map_pkg::ROW_W-1:0] row;
  logic [sdram_map_pkg::COL_W-1:0] col;
  logic [1:0] offset;
  logic [sdram_map_pkg::LANES-1:0] lane_en;
  modport producer (output bank_field, output row, output col, output offset, output lane_en);
  modport consumer (input bank_field, input row, input col, input offset, input lane_en);
endinterface
`default_nettype wire

/* File: design/sdram_address_mapper.sv */
// sdram address mapper: request port to single-location sdram commands
//
// How it works
// - chip select, row strobe, column strobe and write strobe are low when asserted, high idle.
// - four active-low byte-lane masks, one per data byte, low enables the lane.
// - the bank/row/column split follows the configured rows, columns and bus width.
// - on a 32-bit bus address bits 1:0 are the byte offset and only pick lanes.
// - on a 16-bit bus address bit 0 is the byte offset and the column starts at bit 1.
// - the column sits right above the offset, 8 to 11 bits for 256 to 2048 columns.
// - the row sits right above the column, 11 to 13 bits for 2K to 8K rows.
// - a two-bit bank sits above the row, upper bit on bank pin 1, lower on bank pin 0.
// - 32-bit, 8K rows, 2048 columns gives columns 12:2, rows 25:13, bank 27:26.
// - a 16-bit bus moves every field down one bit, e.g. 2K/256 gives 8:1, 19:9, 21:20.
// - the requester sees plain linear memory; the command protocol stays inside.
// - byte, half-word and word accesses enable only the lanes their size and offset pick.
// - reads and writes move one location each and the open row is kept per bank.
`timescale 1ns/1ns
`default_nettype none
module sdram_address_mapper (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [1:0] req_size_i,
  input wire logic [sdram_map_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [sdram_map_pkg::DATA_W-1:0] req_wdata_i,
  output logic resp_valid_o,
  output logic [sdram_map_pkg::DATA_W-1:0] resp_rdata_o,
  input wire logic [1:0] cfg_rows_i,
  input wire logic [1:0] cfg_cols_i,
  input wire logic cfg_bus16_i,
  input wire logic low_power_i,
  output logic mem_clock_out_o,
  output logic mem_clock_enable_o,
  output logic mem_chip_select_n_o,
  output logic mem_row_strobe_n_o,
  output logic mem_col_strobe_n_o,
  output logic mem_write_strobe_n_o,
  output logic [1:0] mem_bank_select_o,
  output logic [sdram_map_pkg::PIN_ADDR_W-1:0] mem_address_out_o,
  output logic [sdram_map_pkg::LANES-1:0] byte_lane_mask_n_o,
  input wire logic [sdram_map_pkg::DATA_W-1:0] mem_data_i,
  output logic [sdram_map_pkg::DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_o
);
  // ------------------------------------------------------------
  // request capture and address split
  // ------------------------------------------------------------
  sdram_map_pkg::state_e state_r, state_nxt;
  logic [sdram_map_pkg::ADDR_W-1:0] addr_r;
  logic [1:0] size_r;
  logic write_r;
  logic [sdram_map_pkg::DATA_W-1:0] wdata_r;
  logic div_r;
  logic [sdram_map_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic [3:0] open_vld_r;
  logic [sdram_map_pkg::ROW_W-1:0] open_row_r [4];
  logic [sdram_map_pkg::DATA_W-1:0] din_meta_r, din_sync_r;
  logic cke_r;
  logic [1:0] bank_pin_r;
  logic [sdram_map_pkg::PIN_ADDR_W-1:0] addr_pin_r, addr_pin_nxt;
  logic [3:0] mask_n_r;
  logic [sdram_map_pkg::DATA_W-1:0] rdata_r;
  logic oe_r;

  map_fields_if fld ();

  addr_splitter u_split (
    .addr_i(addr_r),
    .size_i(size_r),
    .cfg_rows_i(cfg_rows_i),
    .cfg_cols_i(cfg_cols_i),
    .cfg_bus16_i(cfg_bus16_i),
    .fld(fld.producer)
  );

  // memory clock runs at half rate; tick marks the edge where pins may change
  wire tick = div_r;
  wire accept = req_valid_i && req_ready_o;
  wire row_hit = open_vld_r[fld.bank_field] && (open_row_r[fld.bank_field] == fld.row);
  wire row_open = open_vld_r[fld.bank_field];
  wire issue_tick = (state_r == sdram_map_pkg::ST_ISSUE) && tick;
  wire do_pre = issue_tick && !row_hit && row_open;
  wire do_act = issue_tick && !row_open;
  wire do_rw = issue_tick && row_hit;
  // column bit 10 goes on pin 11 so pin 10 stays free as the auto-precharge flag
  wire [12:0] col_pins = {1'b0, fld.col[10], 1'b0, fld.col[9:0]};

  assign req_ready_o = (state_r == sdram_map_pkg::ST_IDLE) && cke_r && !low_power_i;
  assign resp_valid_o = (state_r == sdram_map_pkg::ST_DONE);

  always_ff @(posedge sys_clk_i)
  begin
    if (accept)
    begin
      addr_r <= req_addr_i;
      size_r <= req_size_i;
      write_r <= req_write_i;
      wdata_r <= req_wdata_i;
    end
  end

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    addr_pin_nxt = addr_pin_r;
    if (tick)
    begin
      cmd_nxt = (state_r == sdram_map_pkg::ST_IDLE) ? sdram_map_pkg::CMD_DESEL
                                                    : sdram_map_pkg::CMD_NOP;
    end
    case (state_r)
      sdram_map_pkg::ST_IDLE:
      begin
        if (accept)
          state_nxt = sdram_map_pkg::ST_ISSUE;
      end
      sdram_map_pkg::ST_ISSUE:
      begin
        if (do_rw)
        begin
          cmd_nxt = write_r ? sdram_map_pkg::CMD_WRITE : sdram_map_pkg::CMD_READ;
          addr_pin_nxt = col_pins;
          cnt_nxt = sdram_map_pkg::CAS_TICKS;
          state_nxt = write_r ? sdram_map_pkg::ST_DONE : sdram_map_pkg::ST_RDWAIT;
        end
        else if (do_pre)
        begin
          cmd_nxt = sdram_map_pkg::CMD_PRE;
          addr_pin_nxt = '0;
          cnt_nxt = sdram_map_pkg::TRP_TICKS;
          state_nxt = sdram_map_pkg::ST_GAP;
        end
        else if (do_act)
        begin
          cmd_nxt = sdram_map_pkg::CMD_ACT;
          addr_pin_nxt = fld.row;
          cnt_nxt = sdram_map_pkg::TRCD_TICKS;
          state_nxt = sdram_map_pkg::ST_GAP;
        end
      end
      sdram_map_pkg::ST_GAP:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r - 4'h1;
          if (cnt_r <= 4'h1)
            state_nxt = sdram_map_pkg::ST_ISSUE;
        end
      end
      sdram_map_pkg::ST_RDWAIT:
      begin
        // one tick more than the latency covers the data synchroniser
        if (tick)
        begin
          cnt_nxt = cnt_r - 4'h1;
          if (cnt_r == 4'h0)
            state_nxt = sdram_map_pkg::ST_DONE;
        end
      end
      sdram_map_pkg::ST_DONE:
      begin
        state_nxt = sdram_map_pkg::ST_IDLE;
      end
      default:
      begin
        state_nxt = sdram_map_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= sdram_map_pkg::ST_IDLE;
      cnt_r <= '0;
      cmd_r <= sdram_map_pkg::CMD_DESEL;
      addr_pin_r <= '0;
      div_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
      addr_pin_r <= addr_pin_nxt;
      div_r <= !div_r;
    end
  end

  // ------------------------------------------------------------
  // open row per bank
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      open_vld_r <= '0;
    else if (do_pre)
      open_vld_r[fld.bank_field] <= 1'b0;
    else if (do_act)
      open_vld_r[fld.bank_field] <= 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (do_act)
      open_row_r[fld.bank_field] <= fld.row;
  end

  // ------------------------------------------------------------
  // pins: bank, masks, data, clock enable
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      bank_pin_r <= '0;
      mask_n_r <= sdram_map_pkg::MASK_ALL_N;
      oe_r <= 1'b0;
      cke_r <= 1'b1;
    end
    else
    begin
      if (issue_tick)
        bank_pin_r <= fld.bank_field;
      if (tick)
        mask_n_r <= do_rw ? ~fld.lane_en : sdram_map_pkg::MASK_ALL_N;
      if (tick)
        oe_r <= do_rw && write_r;
      cke_r <= !(low_power_i && (state_r == sdram_map_pkg::ST_IDLE));
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      din_meta_r <= '0;
      din_sync_r <= '0;
      rdata_r <= '0;
      mem_data_o <= '0;
    end
    else
    begin
      din_meta_r <= mem_data_i;
      din_sync_r <= din_meta_r;
      if ((state_r == sdram_map_pkg::ST_RDWAIT) && (state_nxt == sdram_map_pkg::ST_DONE))
        rdata_r <= din_sync_r;
      if (accept)
        mem_data_o <= req_wdata_i;
    end
  end

  assign mem_clock_out_o = div_r;
  assign mem_clock_enable_o = cke_r;
  assign {mem_chip_select_n_o, mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_strobe_n_o} = cmd_r;
  assign mem_bank_select_o = bank_pin_r;
  assign mem_address_out_o = addr_pin_r;
  assign byte_lane_mask_n_o = mask_n_r;
  assign mem_data_oe_o = oe_r;
  assign resp_rdata_o = rdata_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_IDLE_HIGH: assert property ((state_r == sdram_map_pkg::ST_IDLE) && $past(tick) |-> mem_chip_select_n_o && mem_row_strobe_n_o && mem_col_strobe_n_o && mem_write_strobe_n_o) else $error("strobes not idle high");
  AST_WORD_LANES: assert property (do_rw && !cfg_bus16_i && (size_r == sdram_map_pkg::SIZE_WORD) |=> byte_lane_mask_n_o == 4'h0) else $error("word access masks wrong");
  AST_BYTE16_LANES: assert property (do_rw && cfg_bus16_i && (size_r == sdram_map_pkg::SIZE_BYTE) |=> byte_lane_mask_n_o == (addr_r[0] ? 4'hD : 4'hE)) else $error("16-bit byte mask wrong");
  AST_MAP_32_MAX: assert property (!cfg_bus16_i && cfg_rows_i == sdram_map_pkg::ROWS_8K && cfg_cols_i == sdram_map_pkg::COLS_2048 |-> fld.col == addr_r[12:2] && fld.row == addr_r[25:13] && fld.bank_field == addr_r[27:26]) else $error("32-bit map wrong");
  AST_MAP_16_MIN: assert property (cfg_bus16_i && cfg_rows_i == sdram_map_pkg::ROWS_2K && cfg_cols_i == sdram_map_pkg::COLS_256 |-> fld.col == {3'h0, addr_r[8:1]} && fld.row == {2'h0, addr_r[19:9]} && fld.bank_field == addr_r[21:20]) else $error("16-bit map wrong");
  AST_ACT_PINS: assert property (do_act |=> mem_address_out_o == fld.row && mem_bank_select_o == fld.bank_field && !mem_row_strobe_n_o) else $error("activate pins wrong");
  AST_PRE_ACT: assert property (do_pre |=> ##[1:12] (cmd_r == sdram_map_pkg::CMD_ACT)) else $error("precharge not followed by activate");
  AST_CKE_BUSY: assert property (state_r != sdram_map_pkg::ST_IDLE |-> mem_clock_enable_o) else $error("clock enable low while busy");
  AST_REQ_RESP: assert property (accept |-> ##[2:40] resp_valid_o) else $error("request not answered");

  COV_READ_HIT: cover property (do_rw && !write_r);
  COV_WRITE: cover property (do_rw && write_r);
  COV_ROW_MISS: cover property (do_pre);
  COV_BUS16: cover property (resp_valid_o && cfg_bus16_i);
endmodule
`default_nettype wire

/* File: design/sdram_map_pkg.sv */
// shared constants, commands and states of the sdram address mapper
package sdram_map_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int PIN_ADDR_W = 13;
  localparam int ROW_W = 13;
  localparam int COL_W = 11;
  localparam int LANES = 4;
  localparam int CNT_W = 4;
  // ------------------------------------------------------------
  // geometry codes and field positions
  // ------------------------------------------------------------
  localparam logic [1:0] ROWS_2K = 2'h0;
  localparam logic [1:0] ROWS_4K = 2'h1;
  localparam logic [1:0] ROWS_8K = 2'h2;
  localparam logic [1:0] COLS_256 = 2'h0;
  localparam logic [1:0] COLS_2048 = 2'h3;
  localparam logic [4:0] COL_LSB_32 = 5'h02;
  localparam logic [4:0] COL_LSB_16 = 5'h01;
  localparam logic [4:0] COL_W_MIN = 5'h08;
  localparam logic [4:0] ROW_W_MIN = 5'h0B;
  localparam int PIN_AP_BIT = 10;
  // ------------------------------------------------------------
  // access sizes
  // ------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // ------------------------------------------------------------
  // pin commands {chip select, row strobe, column strobe, write strobe}
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_DESEL = 4'hF;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  // ------------------------------------------------------------
  // timing; one memory clock period is two system cycles
  // ------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int TICK_NS = 2 * CLK_NS;
  localparam int TRP_NS = 20;
  localparam int TRCD_NS = 20;
  localparam logic [CNT_W-1:0] TRP_TICKS = CNT_W'((TRP_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [CNT_W-1:0] TRCD_TICKS = CNT_W'((TRCD_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [CNT_W-1:0] CAS_TICKS = 4'h2;
  localparam logic [3:0] MASK_ALL_N = 4'hF;
  // ------------------------------------------------------------
  // controller states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_GAP = 3'b010,
    ST_RDWAIT = 3'b011,
    ST_DONE = 3'b100
  } state_e;
endpackage

/* File: test/sdram_model.sv */
// behavioural sdram device: per-bank open rows, byte-masked storage, protocol monitor
`timescale 1ns/1ns
`default_nettype none
module sdram_model (
  input wire logic clk_i,
  input wire logic cke_i,
  input wire logic [3:0] cmd_i,
  input wire logic [1:0] bank_i,
  input wire logic [12:0] addr_i,
  input wire logic [3:0] mask_n_i,
  input wire logic [31:0] wdata_i,
  input wire logic oe_i,
  output logic [31:0] rdata_o,
  output logic [1:0] last_bank_o,
  output logic [12:0] last_row_o,
  output logic [10:0] last_col_o,
  output logic [3:0] last_mask_n_o,
  output logic [15:0] act_cnt_o,
  output logic [15:0] err_cnt_o
);
  logic [31:0] mem [logic [25:0]];
  logic [12:0] open_row [4];
  logic [3:0] is_open = 4'h0;
  logic [31:0] rd_word = 32'h0;
  logic [3:0] rd_age = 4'hF;
  logic [25:0] key;
  logic [31:0] cur;
  initial
  begin
    act_cnt_o = 16'h0;
    err_cnt_o = 16'h0;
  end
  assign key = {bank_i, open_row[bank_i], addr_i[11], addr_i[9:0]};
  // cas latency two: data leaves after the clock one past the read and holds
  // two clocks; elsewhere the bus shows the inverse so a late sample fails
  assign rdata_o = (rd_age >= 4'h1 && rd_age <= 4'h2) ? rd_word : ~rd_word;
  always @(posedge clk_i)
  begin
    if (rd_age != 4'hF)
      rd_age = rd_age + 4'h1;
    if (cke_i)
    begin
      case (cmd_i)
        sdram_map_pkg::CMD_ACT:
        begin
          if (is_open[bank_i])
            err_cnt_o = err_cnt_o + 16'h1;
          open_row[bank_i] = addr_i;
          is_open[bank_i] = 1'b1;
          act_cnt_o = act_cnt_o + 16'h1;
        end
        sdram_map_pkg::CMD_PRE: is_open[bank_i] = 1'b0;
        sdram_map_pkg::CMD_READ, sdram_map_pkg::CMD_WRITE:
        begin
          if (!is_open[bank_i])
            err_cnt_o = err_cnt_o + 16'h1;
          last_bank_o = bank_i;
          last_row_o = open_row[bank_i];
          last_col_o = {addr_i[11], addr_i[9:0]};
          last_mask_n_o = mask_n_i;
          cur = mem.exists(key) ? mem[key] : 32'h0;
          if (cmd_i == sdram_map_pkg::CMD_WRITE)
          begin
            if (oe_i !== 1'b1)
              err_cnt_o = err_cnt_o + 16'h1;
            for (int l = 0; l < 4; l++)
              if (!mask_n_i[l])
                cur[8*l+:8] = wdata_i[8*l+:8];
            mem[key] = cur;
          end
          else
          begin
            rd_word = cur;
            rd_age = 4'h0;
          end
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_sdram_address_mapper.sv */
// self-checking bench of the sdram address mapper against a behavioural device
`timescale 1ns/1ns
`default_nettype none
module tb_sdram_address_mapper;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_size = 2'h0;
  logic [27:0] req_addr = 28'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [1:0] cfg_rows = 2'h0;
  logic [1:0] cfg_cols = 2'h0;
  logic cfg_bus16 = 1'b0;
  logic low_power = 1'b0;
  logic req_ready, resp_valid, mem_clk, cke, cs_n, ras_n, cas_n, we_n, oe;
  logic [31:0] resp_rdata, mem_din, mem_dout;
  logic [1:0] bank, last_bank;
  logic [12:0] maddr, last_row;
  logic [10:0] last_col;
  logic [3:0] mask_n, last_mask_n;
  logic [15:0] act_cnt, err_cnt;
  int failures = 0;
  int total_checks = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  sdram_address_mapper u_sdram_address_mapper (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_write_i(req_write), .req_size_i(req_size),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .resp_valid_o(resp_valid),
    .resp_rdata_o(resp_rdata), .cfg_rows_i(cfg_rows), .cfg_cols_i(cfg_cols),
    .cfg_bus16_i(cfg_bus16), .low_power_i(low_power), .mem_clock_out_o(mem_clk),
    .mem_clock_enable_o(cke), .mem_chip_select_n_o(cs_n), .mem_row_strobe_n_o(ras_n),
    .mem_col_strobe_n_o(cas_n), .mem_write_strobe_n_o(we_n), .mem_bank_select_o(bank),
    .mem_address_out_o(maddr), .byte_lane_mask_n_o(mask_n), .mem_data_i(mem_din),
    .mem_data_o(mem_dout), .mem_data_oe_o(oe)
  );
  sdram_model u_sdram_model (
    .clk_i(mem_clk), .cke_i(cke), .cmd_i({cs_n, ras_n, cas_n, we_n}), .bank_i(bank),
    .addr_i(maddr), .mask_n_i(mask_n), .wdata_i(mem_dout), .oe_i(oe), .rdata_o(mem_din),
    .last_bank_o(last_bank), .last_row_o(last_row), .last_col_o(last_col),
    .last_mask_n_o(last_mask_n), .act_cnt_o(act_cnt), .err_cnt_o(err_cnt)
  );
  // ------------------------------------------------------------
  // compare and bus tasks
  // ------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    check_word({31'h0, got}, {31'h0, exp}, what);
  endtask
  // request held from a falling edge until a rising edge sees ready
  task automatic access(input logic wr, input logic [1:0] sz, input logic [27:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    req_valid = 1'b1;
    req_write = wr;
    req_size = sz;
    req_addr = a;
    req_wdata = wd;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    @(negedge sys_clk_i);
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 60)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    check_bit(resp_valid, 1'b1, "response");
    rd = resp_rdata;
    repeat (2) @(negedge sys_clk_i);
  endtask
  function automatic logic [3:0] lanes_of(input logic b16, input logic [1:0] sz,
                                         input logic [1:0] off);
    if (b16)
      return (sz == sdram_map_pkg::SIZE_BYTE) ? (off[0] ? 4'h2 : 4'h1) : 4'h3;
    if (sz == sdram_map_pkg::SIZE_BYTE)
      return 4'h1 << off;
    if (sz == sdram_map_pkg::SIZE_HALF)
      return off[1] ? 4'hC : 4'h3;
    return 4'hF;
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_idle();
    check_word({28'h0, cs_n, ras_n, cas_n, we_n}, 32'hF, "idle strobes");
    check_word({28'h0, mask_n}, 32'hF, "idle masks");
    check_bit(cke, 1'b1, "cke");
    check_bit(oe, 1'b0, "oe");
    check_bit(req_ready, 1'b1, "ready");
  endtask
  // every geometry, reserved row code too; word write then read back, fields at the pins
  task automatic test_fields();
    logic [27:0] a;
    logic [31:0] d, r, keep;
    int off, cw, rw;
    for (int b = 0; b < 2; b++)
      for (int rr = 0; rr < 4; rr++)
        for (int cc = 0; cc < 4; cc++)
        begin
          cfg_bus16 = b[0];
          cfg_rows = 2'(rr);
          cfg_cols = 2'(cc);
          off = b ? 1 : 2;
          cw = 8 + cc;
          // the reserved row code is taken as the largest row count
          rw = (rr > 2) ? 13 : 11 + rr;
          a = 28'hB6D5A94 & (b ? ~28'h1 : ~28'h3);
          d = 32'hC3A50000 | 32'(b * 16 + rr * 4 + cc);
          keep = b ? 32'h0000FFFF : 32'hFFFFFFFF;
          access(1'b1, sdram_map_pkg::SIZE_WORD, a, d, r);
          check_word(32'(last_col), 32'((a >> off) & ((28'h1 << cw) - 1)), "col");
          check_word(32'(last_row), 32'((a >> (off + cw)) & ((28'h1 << rw) - 1)), "row");
          check_word(32'(last_bank), 32'((a >> (off + cw + rw)) & 28'h3), "bank");
          access(1'b0, sdram_map_pkg::SIZE_WORD, a, 32'h0, r);
          check_word(r & keep, d & keep, "readback");
        end
  endtask
  // every size at each aligned offset on both widths; masks and merged data
  task automatic test_lanes();
    logic [31:0] r, m, keep;
    logic [3:0] ln;
    cfg_rows = 2'h0;
    cfg_cols = 2'h0;
    for (int b = 0; b < 2; b++)
      for (int s = 0; s < 3; s++)
        for (int o = 0; o < (b ? 2 : 4); o++)
        begin
          if ((s == 1 && o[0]) || (s == 2 && o != 0))
            continue;
          cfg_bus16 = b[0];
          ln = lanes_of(b[0], 2'(s), 2'(o));
          m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
          keep = b ? 32'h0000FFFF : 32'hFFFFFFFF;
          access(1'b1, sdram_map_pkg::SIZE_WORD, 28'h100, 32'h11223344, r);
          access(1'b1, 2'(s), 28'h100 + 28'(o), 32'hA0B1C2D3, r);
          check_word({28'h0, last_mask_n}, {28'h0, ~ln}, "lane mask");
          access(1'b0, sdram_map_pkg::SIZE_WORD, 28'h100, 32'h0, r);
          check_word(r & keep, ((32'h11223344 & ~m) | (32'hA0B1C2D3 & m)) & keep, "merge");
        end
  endtask
  // rows stay open per bank; a miss in one bank costs exactly one activate
  task automatic test_rows();
    logic [31:0] r;
    logic [15:0] n0;
    cfg_bus16 = 1'b0;
    access(1'b1, sdram_map_pkg::SIZE_WORD, 28'h0000400, 32'h0BADF00D, r);
    access(1'b1, sdram_map_pkg::SIZE_WORD, 28'h0200C00, 32'h600DCAFE, r);
    n0 = act_cnt;
    access(1'b0, sdram_map_pkg::SIZE_WORD, 28'h0000400, 32'h0, r);
    check_word(r, 32'h0BADF00D, "bank0 hit");
    access(1'b0, sdram_map_pkg::SIZE_WORD, 28'h0200C00, 32'h0, r);
    check_word(r, 32'h600DCAFE, "bank1 hit");
    check_word({16'h0, act_cnt}, {16'h0, n0}, "no activate on hits");
    access(1'b1, sdram_map_pkg::SIZE_WORD, 28'h0000800, 32'h12345678, r);
    check_word({16'h0, act_cnt}, {16'h0, n0 + 16'h1}, "miss activate");
    access(1'b0, sdram_map_pkg::SIZE_WORD, 28'h0000400, 32'h0, r);
    check_word(r, 32'h0BADF00D, "reopened row");
    check_word({16'h0, act_cnt}, {16'h0, n0 + 16'h2}, "second miss");
  endtask
  task automatic test_low_power();
    @(negedge sys_clk_i);
    low_power = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    check_bit(cke, 1'b0, "cke in low power");
    check_bit(req_ready, 1'b0, "ready in low power");
    low_power = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    check_bit(cke, 1'b1, "cke after low power");
    check_bit(req_ready, 1'b1, "ready after low power");
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    @(negedge sys_clk_i);
    test_idle();
    test_fields();
    test_lanes();
    test_rows();
    test_low_power();
    test_idle();
    check_word({16'h0, err_cnt}, 32'h0, "device protocol");
    report_and_stop();
  end
  // about 100 accesses of at most 164 cycles each fit well inside this span
  initial
  begin
    #1000000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
